/* hdl/sbra_core.sv */
// command interpreter for register read and write in command and response mode
`include "sbra_map.svh"

// frame timing, counted from the edge that takes a frame (cycle 0):
//   cycle 1       ready low, a write has landed, the answer body is built
//   cycles 2-41   forty crc shifts, one bit per clock, msb first
//   cycle 42      the crc engine reports done
//   cycle 43      one-cycle answer pulse, ready high again
// dropped frames and foreign codes keep ready high, so the next frame may
// follow at once; only an answered frame holds the interface off.
// a frame offered while busy is held off, never queued: the receiver in
// front of this block must keep it until ready returns.
// a polynomial write already shapes the crc of its own answer, because the
// engine starts one cycle after the write has landed.
// a reset at any point clears the interpreter and the crc engine together,
// so no answer begun before the reset can appear after it.
// the address register keeps four bits; its upper nibble always reads zero.

module sbra_core #(
  parameter logic [3:0] PHYS_RST = `SBRA_PHYS_RST,
  parameter logic [7:0] POLY_RST = `SBRA_POLY_RST
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic frame_valid_i,
  input sbra_pkg::sbra_frame_t frame_i,
  output logic frame_ready_o,
  output logic resp_valid_o,
  output sbra_pkg::sbra_resp_t resp_o,
  output logic other_cmd_o,
  output logic [3:0] phys_addr_o
);
  import sbra_pkg::*;

  sbra_st_t s_q;
  sbra_st_t s_d;
  // hand-off to the crc engine
  logic crc_start;
  logic [31:0] crc_data;
  logic crc_done;
  logic [7:0] crc_val;
  // address decode and readback
  logic own_hit;
  logic glob_hit;
  logic [8:0] rd_lo;
  logic [8:0] rd_hi;
  // one write strobe per scratch byte
  logic [`SBRA_USER_DEPTH-1:0] user_we;

  // true for the scratch byte range; the lower bound stays in case the bank moves
  function automatic logic is_user(input logic [7:0] a);
    is_user = (a >= `SBRA_OFS_USER) && (a < (`SBRA_OFS_USER + 8'(`SBRA_USER_DEPTH)));
  endfunction : is_user

  // {readable, value}; unmapped bytes read as zero and flag not readable
  // bits 7:4 of the address register are not stored and read back as zero
  function automatic logic [8:0] rd_byte(input sbra_st_t st, input logic [7:0] a);
    logic [7:0] idx;
    idx = a - `SBRA_OFS_USER;
    rd_byte = 9'h000;
    if (a == `SBRA_OFS_PHYS) begin
      rd_byte = {1'b1, 4'h0, st.phys};
    end else if (a == `SBRA_OFS_POLY) begin
      rd_byte = {1'b1, st.poly};
    end else if (is_user(a)) begin
      rd_byte = {1'b1, st.user[idx[`SBRA_USER_AW-1:0]]};
    end
  endfunction : rd_byte

  // every readable byte here is also writable
  // a write anywhere else stores nothing and is answered with zeros
  function automatic logic wr_ok(input logic [7:0] a);
    wr_ok = (a == `SBRA_OFS_PHYS) || (a == `SBRA_OFS_POLY) || is_user(a);
  endfunction : wr_ok

  // address match; the global address never counts as an own match
  // an unassigned device sits at address 0 and must not answer addressed frames
  assign own_hit = (frame_i.addr == s_q.phys) && (frame_i.addr != `SBRA_GLOBAL_ADDR);

  // global assignment only while still unassigned and only to the address register
  // bits 7:4 of the data byte are ignored, only four address bits exist
  assign glob_hit = (frame_i.addr == `SBRA_GLOBAL_ADDR) && (frame_i.cmd == `SBRA_CMD_WRITE)
                    && (frame_i.hi == `SBRA_OFS_PHYS)
                    && (s_q.phys == `SBRA_GLOBAL_ADDR);

  // readback is taken from the registered state, so writes are already visible
  assign rd_lo = rd_byte(s_q, s_q.ra);
  assign rd_hi = rd_byte(s_q, s_q.ra + 8'h01);

  // per byte write strobes of the scratch bank; only an accepted write frame
  // can raise one, so a dropped frame never disturbs a scratch byte
  for (genvar g = 0; g < `SBRA_USER_DEPTH; g++) begin : g_user_we
    assign user_we[g] = frame_valid_i && (s_q.state == SBRA_IDLE)
                        && (frame_i.cmd == `SBRA_CMD_WRITE)
                        && (own_hit || glob_hit)
                        && is_user(frame_i.hi)
                        && (int'(frame_i.hi[`SBRA_USER_AW-1:0]) == g);
  end

  // next state of the interpreter
  always_comb begin
    s_d = s_q;
    s_d.resp_valid = 1'b0;
    s_d.other = 1'b0;
    crc_start = 1'b0;
    crc_data = 32'h0000_0000;
    case (s_q.state)
      SBRA_IDLE: begin
        if (frame_valid_i) begin
          // latched even for dropped frames; harmless, only an accepted frame leaves idle
          s_d.cmd = frame_i.cmd;
          s_d.ra = frame_i.hi;
          if (frame_i.cmd == `SBRA_CMD_READ) begin
            // a foreign or global read simply leaves the machine idle
            if (own_hit) begin
              s_d.state = SBRA_PREP;
              s_d.bad = 1'b0;
            end
          end else if (frame_i.cmd == `SBRA_CMD_WRITE) begin
            if (own_hit || glob_hit) begin
              s_d.state = SBRA_PREP;
              s_d.bad = !wr_ok(frame_i.hi);
              // the write lands before the answer body is built
              if (frame_i.hi == `SBRA_OFS_PHYS) begin
                s_d.phys = frame_i.lo[`SBRA_PHYS_MSB:0];
              end else if (frame_i.hi == `SBRA_OFS_POLY) begin
                s_d.poly = frame_i.lo;
              end else begin
                // scratch bytes take their strobes from the generate loop
                for (int k = 0; k < `SBRA_USER_DEPTH; k++) begin
                  if (user_we[k]) begin
                    s_d.user[k] = frame_i.lo;
                  end
                end
              end
            end
          end else begin
            // not ours to answer; pass the event on
            s_d.other = 1'b1;
          end
        end
      end
      SBRA_PREP: begin
        // address field is the register value after any write
        s_d.body.addr = s_q.phys;
        s_d.body.cmd = s_q.cmd;
        // an unreadable read and any unwritable write both answer zeros
        if (s_q.bad || (s_q.cmd == `SBRA_CMD_READ && !rd_lo[8])) begin
          s_d.body.hi = 8'h00;
          s_d.body.lo = 8'h00;
        end else begin
          s_d.body.hi = rd_hi[7:0];
          s_d.body.lo = rd_lo[7:0];
        end
        // the engine copies the message on this edge; body keeps it for the answer
        crc_start = 1'b1;
        // the crc slot enters the message as eight zero bits behind the body
        crc_data = {s_d.body, 8'h00};
        s_d.state = SBRA_CALC;
      end
      SBRA_CALC: begin
        // the body is held since cycle 1; only the crc joins it here
        if (crc_done) begin
          s_d.resp = {s_q.body, crc_val};
          s_d.resp_valid = 1'b1;
          s_d.state = SBRA_IDLE;
        end
      end
      default: begin
        // an illegal state code falls back to idle instead of hanging the link
        s_d.state = SBRA_IDLE;
      end
    endcase
  end

  // state register with synchronous reset
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      // all fields clear, scratch bytes included; then the non-zero defaults
      s_q <= '0;
      s_q.state <= SBRA_IDLE;
      s_q.phys <= PHYS_RST;
      s_q.poly <= POLY_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // crc engine; the polynomial register is read live, it cannot change mid frame
  // sharing the reset keeps a half finished crc from surfacing after a reset
  sbra_crc u_crc (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .start_i(crc_start),
    .data_i(crc_data),
    .poly_i(s_q.poly),
    .done_o(crc_done),
    .crc_o(crc_val)
  );

  // one frame at a time; busy frames are held off by the ready handshake
  // resp_o keeps the last answer until the next one is complete
  assign frame_ready_o = (s_q.state == SBRA_IDLE);
  assign resp_valid_o = s_q.resp_valid;
  assign resp_o = s_q.resp;
  assign other_cmd_o = s_q.other;
  assign phys_addr_o = s_q.phys;

endmodule : sbra_core

/* hdl/sbra_crc.sv */
// bit serial crc generator for response frames
`include "sbra_map.svh"

module sbra_crc (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic start_i,
  input wire logic [31:0] data_i,
  input wire logic [7:0] poly_i,
  output logic done_o,
  output logic [7:0] crc_o
);
  import sbra_pkg::*;

  sbra_crc_st_t s_q;
  sbra_crc_st_t s_d;

  // one message bit per clock, msb first, then eight zeros; poly sampled live
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (start_i) begin
      s_d.busy = 1'b1;
      s_d.cnt = `SBRA_CRC_SHIFTS;
      s_d.sh = {data_i, 8'h00};
      s_d.crc = `SBRA_CRC_SEED;
    end else if (s_q.busy) begin
      s_d.crc = {s_q.crc[6:0], s_q.sh[39]} ^ (s_q.crc[7] ? poly_i : 8'h00);
      s_d.sh = {s_q.sh[38:0], 1'b0};
      s_d.cnt = s_q.cnt - 6'h01;
      if (s_q.cnt == 6'h01) begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign done_o = s_q.done;
  assign crc_o = s_q.crc;

endmodule : sbra_crc

/* hdl/sbra_map.svh */
// register offsets, command codes, reset values and counts of the register access block
`ifndef SBRA_MAP_SVH
`define SBRA_MAP_SVH

// command codes seen in the command field
`define SBRA_CMD_READ 4'h0
`define SBRA_CMD_WRITE 4'h8

// global device address, also the value of an unassigned device
`define SBRA_GLOBAL_ADDR 4'h0

// register byte offsets
`define SBRA_OFS_USER 8'h00
`define SBRA_OFS_PHYS 8'h11
`define SBRA_OFS_POLY 8'h20

// user scratch bytes start at SBRA_OFS_USER
`define SBRA_USER_DEPTH 16
`define SBRA_USER_AW 4

// field layout of the physical address register
`define SBRA_PHYS_MSB 3

// reset values
`define SBRA_PHYS_RST 4'h0
`define SBRA_POLY_RST 8'h2f
`define SBRA_CRC_SEED 8'hff

// 32 message bits followed by 8 zero bits
`define SBRA_CRC_SHIFTS 6'h28

`endif

/* hdl/sbra_pkg.sv */
// types shared by the register access block
package sbra_pkg;

  // command frame body and response body share one layout
  typedef struct packed {
    logic [3:0] addr;
    logic [3:0] cmd;
    logic [7:0] hi;
    logic [7:0] lo;
  } sbra_frame_t;

  typedef struct packed {
    sbra_frame_t body;
    logic [7:0] crc;
  } sbra_resp_t;

  typedef enum logic [1:0] {
    SBRA_IDLE,
    SBRA_PREP,
    SBRA_CALC
  } sbra_state_t;

  // full state of the command interpreter
  typedef struct packed {
    sbra_state_t state;
    logic [3:0] phys;
    logic [7:0] poly;
    logic [15:0][7:0] user;
    logic [3:0] cmd;
    logic [7:0] ra;
    logic bad;
    sbra_frame_t body;
    sbra_resp_t resp;
    logic resp_valid;
    logic other;
  } sbra_st_t;

  // full state of the serial crc engine
  typedef struct packed {
    logic busy;
    logic [5:0] cnt;
    logic [39:0] sh;
    logic [7:0] crc;
    logic done;
  } sbra_crc_st_t;

endpackage : sbra_pkg

/* test/sbra_core_assertions.sv */
// port checks of the register access block
module sbra_core_assertions (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic frame_valid_i,
  input sbra_pkg::sbra_frame_t frame_i,
  input wire logic frame_ready_o,
  input wire logic resp_valid_o,
  input sbra_pkg::sbra_resp_t resp_o,
  input wire logic other_cmd_o,
  input wire logic [3:0] phys_addr_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import sbra_pkg::*;
  logic tk;
  logic own;
  logic gok;
  logic [3:0] lo_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // own address 0 is unassigned and never matches
  assign tk = frame_valid_i & frame_ready_o;
  assign own = tk & (frame_i.addr == phys_addr_o) & (phys_addr_o != 4'h0);
  assign gok = tk & (frame_i.addr == 4'h0) & (frame_i.cmd == 4'h8) & (frame_i.hi == 8'h11)
    & (phys_addr_o == 4'h0);
  // last low data nibble, to compare against an assigned address
  always_ff @(posedge clk_i) begin
    lo_q <= frame_i.lo[3:0];
  end
  a_read_answer: assert property (own && frame_i.cmd == 4'h0 |-> ##43 resp_valid_o)
    else $error("read to own address not answered");
  a_read_drop: assert property (tk && frame_i.cmd == 4'h0 && !own |=> frame_ready_o)
    else $error("foreign read not dropped");
  a_write_answer: assert property (own && frame_i.cmd == 4'h8 |-> ##43 resp_valid_o)
    else $error("write to own address not answered");
  a_write_drop: assert property (tk && frame_i.cmd == 4'h8 && !own && !gok |=>
    frame_ready_o && $stable(phys_addr_o)) else $error("foreign write not dropped");
  a_glob_assign: assert property (gok |=> phys_addr_o == lo_q ##42
    resp_valid_o && resp_o.body.addr == phys_addr_o) else $error("address assignment wrong");
  a_other_flag: assert property (tk && frame_i.cmd != 4'h0 && frame_i.cmd != 4'h8 |=>
    other_cmd_o && frame_ready_o) else $error("other code not flagged");
  a_resp_fields: assert property (resp_valid_o |-> resp_o.body.addr == phys_addr_o &&
    (resp_o.body.cmd == 4'h0 || resp_o.body.cmd == 4'h8)) else $error("answer header wrong");
  a_busy_hold: assert property ((own && (frame_i.cmd == 4'h0 || frame_i.cmd == 4'h8)) |=>
    !frame_ready_o [*8]) else $error("ready while answering");
endmodule : sbra_core_assertions

/* test/sbra_core_tb.sv */
// testbench of the register access block
module sbra_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import sbra_pkg::*;
  // frame, expected address, answered flag, expected data
  typedef struct packed {
    sbra_frame_t f;
    logic [3:0] a;
    logic [3:0] v;
    logic [15:0] d;
  } sbra_row_t;
  logic clk_i;
  logic sys_rst_i;
  logic frame_valid_i;
  logic frame_ready_o;
  logic resp_valid_o;
  logic other_cmd_o;
  logic [3:0] phys_addr_o;
  sbra_frame_t frame_i;
  sbra_resp_t resp_o;
  int miscompares;
  int n_compared;
  logic [7:0] poly;
  logic ok;
  logic oth;
  logic [39:0] g;
  logic [39:0] e;
  sbra_row_t r;
  sbra_row_t rows [16] = '{48'h0000_0000_0000, 48'h0811_0551_0005, 48'h0811_0700_0000,
    48'h580f_a551_00a5, 48'h580e_3c51_a53c, 48'h500e_0051_a53c, 48'h300e_0000_0000,
    48'h3800_1100_0000, 48'h5040_0051_0000, 48'h5840_ff51_0000, 48'h5b00_0000_0000,
    48'h5100_0000_0000, 48'h5011_0051_0005, 48'h5820_0751_0007, 48'h5020_0051_0007,
    48'h500f_0051_00a5};
  sbra_core i_sbra_core (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .frame_valid_i(frame_valid_i),
    .frame_i(frame_i), .frame_ready_o(frame_ready_o), .resp_valid_o(resp_valid_o),
    .resp_o(resp_o), .other_cmd_o(other_cmd_o), .phys_addr_o(phys_addr_o));
  sbra_master_model i_sbra_master_model (.clk_i(clk_i), .frame_ready_i(frame_ready_o),
    .frame_valid_o(frame_valid_i), .frame_o(frame_i));
  // serial crc, seed all ones, 32 bits then eight zeros
  function automatic logic [7:0] crc(input logic [31:0] m, input logic [7:0] p);
    logic [7:0] c;
    c = 8'hff;
    for (int i = 39; i >= 0; i--) begin
      c = {c[6:0], (i > 7) ? m[i-8] : 1'b0} ^ (c[7] ? p : 8'h00);
    end
    return c;
  endfunction : crc
  task automatic chk(input string n, input logic [39:0] ex, input logic [39:0] got);
    n_compared++;
    if (got !== ex) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", n, ex, got);
    end
  endtask : chk
  // hand one frame to the model; a frame that is never taken ends the run
  task automatic put(input sbra_frame_t f);
    i_sbra_master_model.send(f, ok);
    chk("taken", 40'h1, {39'h0, ok});
    if (ok !== 1'b1) wrap_up();
  endtask : put
  // watch a fixed window; top byte tells whether an answer came; the foreign
  // code flag stands only in the cycle after the take, so it is looked at first
  task automatic grab(output logic [39:0] q, output logic o);
    q = 40'h0;
    #1;
    o = other_cmd_o;
    repeat (50) begin
      @(posedge clk_i);
      #1;
      if (resp_valid_o === 1'b1 && q[32] === 1'b0) q = {8'h01, resp_o};
    end
  endtask : grab
  task automatic wrap_up();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    sys_rst_i = 1'b1;
    miscompares = 0;
    n_compared = 0;
    poly = 8'h2f;
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    // the first frame waits until an edge has seen reset low
    @(posedge clk_i);
    chk("phys_rst", 40'h0, {36'h0, phys_addr_o});
    // table rows: assignment, reads, writes, drops, unmapped places, other codes
    foreach (rows[i]) begin
      r = rows[i];
      put(r.f);
      grab(g, oth);
      // a polynomial write already shapes the crc of its own answer
      if (r.v[0] && r.f.cmd == 4'h8 && r.f.hi == 8'h20) poly = r.f.lo;
      e = r.v[0] ? {8'h01, r.a, r.f.cmd, r.d, crc({r.a, r.f.cmd, r.d, 8'h00}, poly)} : 40'h0;
      chk("resp", e, g);
      chk("other", {39'h0, r.f.cmd != 4'h0 && r.f.cmd != 4'h8}, {39'h0, oth});
      $display("row %0d done", i);
    end
    // reset in mid-answer: no late answer, defaults back, assignment works again
    put(24'h58_0011);
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    grab(g, oth);
    chk("rst_resp", 40'h0, g);
    chk("rst_phys", 40'h0, {36'h0, phys_addr_o});
    poly = 8'h2f;
    put(24'h08_1109);
    grab(g, oth);
    chk("reassign_other", 40'h0, {39'h0, oth});
    chk("reassign", {8'h01, 24'h98_0009, crc(32'h9800_0900, poly)}, g);
    $display("reset test done");
    wrap_up();
  end
endmodule : sbra_core_tb
bind sbra_core sbra_core_assertions i_sbra_core_assertions (.clk_i(clk_i),
  .sys_rst_i(sys_rst_i), .frame_valid_i(frame_valid_i), .frame_i(frame_i),
  .frame_ready_o(frame_ready_o), .resp_valid_o(resp_valid_o), .resp_o(resp_o),
  .other_cmd_o(other_cmd_o), .phys_addr_o(phys_addr_o));

/* test/sbra_master_model.sv */
// bus master model handing command frames to the block
module sbra_master_model (
  input wire logic clk_i,
  input wire logic frame_ready_i,
  output logic frame_valid_o,
  output sbra_pkg::sbra_frame_t frame_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import sbra_pkg::*;
  initial begin
    frame_valid_o = 1'b0;
    frame_o = '0;
  end
  // hold until taken; released data shows the inverse so stale values never match
  task automatic send(input sbra_frame_t f, output logic ok);
    int n;
    n = 0;
    frame_valid_o <= 1'b1;
    frame_o <= f;
    @(posedge clk_i);
    while (frame_ready_i !== 1'b1 && n < 100) begin
      n++;
      @(posedge clk_i);
    end
    ok = (n < 100);
    frame_valid_o <= 1'b0;
    frame_o <= ~f;
  endtask : send
endmodule : sbra_master_model
